/* File: common/ten_base_t_defines.vh */
`ifndef TEN_BASE_T_DEFINES_VH
`define TEN_BASE_T_DEFINES_VH

// Register indices and byte addresses
`define PORT_CTRL_IDX 5'h19
`define TENMB_SC_IDX 5'h1A
`define PORT_CTRL_ADDR 8'h64
`define TENMB_SC_ADDR 8'h68

// Port control tail fields
`define LAMP_SEL_HI 6
`define LAMP_SEL_LO 5
`define PORT_ADDR_HI 4
`define PORT_ADDR_LO 0

// Status/control fields
`define SC_RSVD_HI 14
`define SC_RSVD_LO 12
`define SQUELCH_HI 11
`define SQUELCH_LO 9
`define LOOP_OFF_BIT 8
`define LINK_PULSE_OFF_BIT 7
`define LINK_FORCE_BIT 6
`define POL_FORCE_BIT 5
`define POL_STATUS_BIT 4
`define AUTO_POL_OFF_BIT 3
`define SCALE_MSB_BIT 2
`define SQE_OFF_BIT 1
`define JABBER_OFF_BIT 0

// Reset values
`define SQUELCH_RST 3'h4
`define SC_RSVD_RST 3'h0
`define SCALE_MSB_RST 1'h1
`define LAMP_HI_RST 1'h0

// Lamp scheme encodings
`define LAMP_MODE1 2'h1
`define LAMP_MODE2 2'h2
`define LAMP_MODE3 2'h3

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/sync_bit.v */
`timescale 1ns/1ps
module sync_bit (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Data
    input wire async_in,
    output reg sync_out
);
    reg meta_reg;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // sync_bit

/* File: hdl/ten_base_t_control_regs.v */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ten_base_t_defines.vh"
module ten_base_t_control_regs (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Straps, sampled after reset release
    input wire strap_lamp_lo,
    input wire [4:0] strap_port_addr,
    // Inputs from the rest of the device
    input wire ext_tenmb_link_force,
    input wire basic_loopback,
    input wire silence_off_scale_lsb,
    input wire polarity_inverted_det,
    input wire port_status_read,
    input wire speed_100,
    input wire full_duplex,
    input wire tp_mode_10,
    // Controls to the 10 Mb/s machinery
    output reg [1:0] lamp_scheme_select,
    output reg [4:0] port_addr,
    output reg [2:0] squelch_on_level,
    output reg tenmb_loopback_active,
    output reg link_pulse_tx_off,
    output reg link_good_force,
    output reg rx_polarity_invert,
    output reg auto_polarity_off,
    output reg [1:0] silence_off_level,
    output reg sqe_test_off,
    output reg long_tx_guard_off,
    output reg polarity_status
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

    wire link_force_s;
    wire loop_s;
    wire scale_lsb_s;
    wire pol_det_s;
    wire psts_rd_s;
    wire speed_s;
    wire fdx_s;
    wire tp10_s;
    wire lamp_strap_s;
    wire [4:0] addr_strap_s;

    localparam NSYNC = 14;
    wire [NSYNC-1:0] sync_in;
    wire [NSYNC-1:0] sync_o;
    assign sync_in = {strap_port_addr, strap_lamp_lo, tp_mode_10, full_duplex, speed_100,
                      port_status_read, polarity_inverted_det, silence_off_scale_lsb,
                      basic_loopback, ext_tenmb_link_force};
    assign {addr_strap_s, lamp_strap_s, tp10_s, fdx_s, speed_s, psts_rd_s, pol_det_s,
            scale_lsb_s, loop_s, link_force_s} = sync_o;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            sync_bit u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .async_in(sync_in[gi]),
                .sync_out(sync_o[gi])
            );
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
// Strap capture: two cycles after release the synchronisers hold pin values

    reg [1:0] strap_cnt_reg;
    reg strap_done_reg;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == 2'h2) begin
                strap_done_reg <= 1'b1;
            end
        end
    end

    wire strap_load;
    assign strap_load = !strap_done_reg && (strap_cnt_reg == 2'h2);

////////////////////////////////////////////////////////////////////////////////
// Register storage

    reg lamp_hi_reg;
    reg lamp_lo_reg;
    reg [4:0] paddr_reg;
    reg [2:0] rsvd_reg;
    reg [2:0] squelch_reg;
    reg loop_off_reg;
    reg lp_off_reg;
    reg force_link_reg;
    reg pol_force_reg;
    reg pol_latch_reg;
    reg apol_off_reg;
    reg scale_msb_reg;
    reg sqe_off_reg;
    reg jab_off_reg;

    function [1:0] lamp_decode;
        input hi;
        input lo;
        begin
            if (lo) begin
                lamp_decode = `LAMP_MODE1;
            end else if (!hi) begin
                lamp_decode = `LAMP_MODE2;
            end else begin
                lamp_decode = `LAMP_MODE3;
            end
        end
    endfunction

    function [1:0] reg_sel;
        input [7:0] addr;
        begin
            if (addr == `PORT_CTRL_ADDR) begin
                reg_sel = 2'h1;
            end else if (addr == `TENMB_SC_ADDR) begin
                reg_sel = 2'h2;
            end else begin
                reg_sel = 2'h0;
            end
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write path

    reg aw_held_reg;
    reg w_held_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;

    wire do_write;
    assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    wire [1:0] wsel;
    assign wsel = reg_sel(awaddr_reg);

    always @(posedge core_clk) begin
        if (!rst_n) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read path

    assign s_axi_arready = !s_axi_rvalid;
    wire do_read;
    assign do_read = s_axi_arvalid && s_axi_arready;
    wire [1:0] rsel;
    assign rsel = reg_sel(s_axi_araddr);

    wire [15:0] port_ctrl_rd;
    wire [15:0] tenmb_sc_rd;
    assign port_ctrl_rd = {9'h000, lamp_hi_reg, lamp_lo_reg, paddr_reg};
    assign tenmb_sc_rd = {1'b0, rsvd_reg, squelch_reg, loop_off_reg, lp_off_reg,
                          force_link_reg, pol_force_reg, pol_latch_reg, apol_off_reg,
                          scale_msb_reg, sqe_off_reg, jab_off_reg};

    always @(posedge core_clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            case (rsel)
                2'h1: begin
                    s_axi_rdata <= {16'h0000, port_ctrl_rd};
                    s_axi_rresp <= `RESP_OKAY;
                end
                2'h2: begin
                    s_axi_rdata <= {16'h0000, tenmb_sc_rd};
                    s_axi_rresp <= `RESP_OKAY;
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Field updates

    wire wr_pc;
    wire wr_sc;
    assign wr_pc = do_write && (wsel == 2'h1);
    assign wr_sc = do_write && (wsel == 2'h2);

    // Status read seen by either side clears the latch; new detection wins
    reg psts_rd_d_reg;
    wire psts_rd_pulse;
    assign psts_rd_pulse = psts_rd_s && !psts_rd_d_reg;
    wire pol_clear;
    assign pol_clear = psts_rd_pulse || (do_read && (rsel == 2'h2));

    always @(posedge core_clk) begin
        if (!rst_n) begin
            lamp_hi_reg <= `LAMP_HI_RST;
            lamp_lo_reg <= 1'b0;
            paddr_reg <= 5'h00;
            rsvd_reg <= `SC_RSVD_RST;
            squelch_reg <= `SQUELCH_RST;
            loop_off_reg <= 1'b0;
            lp_off_reg <= 1'b0;
            force_link_reg <= 1'b0;
            pol_force_reg <= 1'b0;
            pol_latch_reg <= 1'b0;
            apol_off_reg <= 1'b0;
            scale_msb_reg <= `SCALE_MSB_RST;
            sqe_off_reg <= 1'b0;
            jab_off_reg <= 1'b0;
            psts_rd_d_reg <= 1'b0;
        end else begin
            psts_rd_d_reg <= psts_rd_s;
            if (strap_load) begin
                lamp_lo_reg <= lamp_strap_s;
                paddr_reg <= addr_strap_s;
            end else if (wr_pc) begin
                if (wstrb_reg[0]) begin
                    lamp_hi_reg <= wdata_reg[`LAMP_SEL_HI];
                    lamp_lo_reg <= wdata_reg[`LAMP_SEL_LO];
                    paddr_reg <= wdata_reg[`PORT_ADDR_HI:`PORT_ADDR_LO];
                end
            end
            if (wr_sc && wstrb_reg[1]) begin
                rsvd_reg <= wdata_reg[`SC_RSVD_HI:`SC_RSVD_LO];
                squelch_reg <= wdata_reg[`SQUELCH_HI:`SQUELCH_LO];
                loop_off_reg <= wdata_reg[`LOOP_OFF_BIT];
            end
            if (wr_sc && wstrb_reg[0]) begin
                lp_off_reg <= wdata_reg[`LINK_PULSE_OFF_BIT];
                force_link_reg <= wdata_reg[`LINK_FORCE_BIT];
                pol_force_reg <= wdata_reg[`POL_FORCE_BIT];
                apol_off_reg <= wdata_reg[`AUTO_POL_OFF_BIT];
                scale_msb_reg <= wdata_reg[`SCALE_MSB_BIT];
                sqe_off_reg <= wdata_reg[`SQE_OFF_BIT];
                jab_off_reg <= wdata_reg[`JABBER_OFF_BIT];
            end
            if (pol_det_s) begin
                pol_latch_reg <= 1'b1;
            end else if (pol_clear) begin
                pol_latch_reg <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
// Registered controls to the 10 Mb/s machinery

    always @(posedge core_clk) begin
        if (!rst_n) begin
            lamp_scheme_select <= `LAMP_MODE2;
            port_addr <= 5'h00;
            squelch_on_level <= `SQUELCH_RST;
            tenmb_loopback_active <= 1'b0;
            link_pulse_tx_off <= 1'b0;
            link_good_force <= 1'b0;
            rx_polarity_invert <= 1'b0;
            auto_polarity_off <= 1'b0;
            silence_off_level <= 2'h2;
            sqe_test_off <= 1'b1;
            long_tx_guard_off <= 1'b0;
            polarity_status <= 1'b0;
        end else begin
            lamp_scheme_select <= lamp_decode(lamp_hi_reg, lamp_lo_reg);
            port_addr <= paddr_reg;
            squelch_on_level <= squelch_reg;
            // Loopback in 10 Mb/s only when neither source disables it
            tenmb_loopback_active <= !(loop_off_reg | loop_s);
            link_pulse_tx_off <= lp_off_reg | link_force_s;
            link_good_force <= force_link_reg | link_force_s;
            rx_polarity_invert <= pol_force_reg;
            auto_polarity_off <= apol_off_reg;
            silence_off_level <= {scale_msb_reg, scale_lsb_s};
            sqe_test_off <= speed_s | fdx_s | sqe_off_reg;
            long_tx_guard_off <= tp10_s & jab_off_reg;
            polarity_status <= pol_latch_reg;
        end
    end

endmodule // ten_base_t_control_regs

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "ten_base_t_defines.vh"
`define CHK(what, exp, got) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
    end \
end
module tb;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, lamp_scheme_select, silence_off_level;
    wire [31:0] s_axi_rdata;
    logic strap_lamp_lo = 1'h0;
    logic [4:0] strap_port_addr = 5'h0;
    logic ext_tenmb_link_force = 1'h0, basic_loopback = 1'h0, silence_off_scale_lsb = 1'h0;
    logic polarity_inverted_det = 1'h0, port_status_read = 1'h0;
    logic speed_100 = 1'h0, full_duplex = 1'h0, tp_mode_10 = 1'h0;
    wire [4:0] port_addr;
    wire [2:0] squelch_on_level;
    wire tenmb_loopback_active, link_pulse_tx_off, link_good_force, rx_polarity_invert;
    wire auto_polarity_off, sqe_test_off, long_tx_guard_off, polarity_status;
    int err_total = 0, num_checks = 0, seed = 84670;
    logic [15:0] sc_m, pc_m;
    logic pol_m;
    logic [1:0] resp;
    logic [31:0] rd, d;
    logic [3:0] s;

    ten_base_t_control_regs i_ten_base_t_control_regs (
        .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_lamp_lo,
        .strap_port_addr, .ext_tenmb_link_force, .basic_loopback, .silence_off_scale_lsb,
        .polarity_inverted_det, .port_status_read, .speed_100, .full_duplex, .tp_mode_10,
        .lamp_scheme_select, .port_addr, .squelch_on_level, .tenmb_loopback_active,
        .link_pulse_tx_off, .link_good_force, .rx_polarity_invert, .auto_polarity_off,
        .silence_off_level, .sqe_test_off, .long_tx_guard_off, .polarity_status
    );

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic axi_wr(input [7:0] a, input [31:0] dat, input [3:0] stb);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= stb;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        // Random late bready makes the response wait in some writes
        s_axi_bready <= 1'($random(seed));
        forever begin
            @(posedge core_clk);
            s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= s_axi_bready || s_axi_bvalid;
        end
        resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic axi_rd(input [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    function automatic logic [31:0] exp_sc();
        return {16'h0, 1'h0, sc_m[14:5], pol_m, sc_m[3:0]};
    endfunction

    task automatic chk_out();
        `CHK("lamp", pc_m[5] ? 2'h1 : (pc_m[6] ? 2'h3 : 2'h2), lamp_scheme_select)
        `CHK("port_addr", pc_m[4:0], port_addr)
        `CHK("squelch", sc_m[11:9], squelch_on_level)
        `CHK("loop", !(sc_m[8] | basic_loopback), tenmb_loopback_active)
        `CHK("pulse", sc_m[7] | ext_tenmb_link_force, link_pulse_tx_off)
        `CHK("link", sc_m[6] | ext_tenmb_link_force, link_good_force)
        `CHK("pol_inv", sc_m[5], rx_polarity_invert)
        `CHK("auto_pol", sc_m[3], auto_polarity_off)
        `CHK("silence", {sc_m[2], silence_off_scale_lsb}, silence_off_level)
        `CHK("sqe", speed_100 | full_duplex | sc_m[1], sqe_test_off)
        `CHK("jabber", tp_mode_10 & sc_m[0], long_tx_guard_off)
        `CHK("pol_stat", pol_m, polarity_status)
    endtask

    task automatic do_reset(input int cycles);
        rst_n <= 1'h0;
        repeat (cycles) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (5) @(posedge core_clk);
        sc_m = 16'h0804;
        pc_m = {9'h0, 1'h0, strap_lamp_lo, strap_port_addr};
        pol_m = 1'h0;
        chk_out();
        axi_rd(`TENMB_SC_ADDR);
        `CHK("sc reset", exp_sc(), rd)
        axi_rd(`PORT_CTRL_ADDR);
        `CHK("pc reset", {16'h0, pc_m}, rd)
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        strap_lamp_lo <= 1'($random(seed));
        strap_port_addr <= 5'($random(seed));
        do_reset(20);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            d[6:5] = 2'(i);
            axi_wr(`PORT_CTRL_ADDR, d, 4'hF);
            `CHK("pc bresp", `RESP_OKAY, resp)
            pc_m[6:0] = d[6:0];
            repeat (2) @(posedge core_clk);
            chk_out();
            axi_rd(`PORT_CTRL_ADDR);
            `CHK("pc read", {16'h0, pc_m}, rd)
        end
        for (int i = 0; i < 24; i++) begin
            d = $random(seed);
            s = 4'($random(seed));
            {speed_100, full_duplex, tp_mode_10, ext_tenmb_link_force, basic_loopback,
                silence_off_scale_lsb} <= 6'($random(seed));
            axi_wr(`TENMB_SC_ADDR, d, s);
            `CHK("sc bresp", `RESP_OKAY, resp)
            if (s[0]) sc_m[7:0] = {d[7:5], 1'h0, d[3:0]};
            if (s[1]) sc_m[15:8] = {1'h0, d[14:8]};
            repeat (4) @(posedge core_clk);
            chk_out();
            axi_rd(`TENMB_SC_ADDR);
            `CHK("sc read", exp_sc(), rd)
        end
        axi_wr(8'h6C, 32'hFFFFFFFF, 4'hF);
        `CHK("bad bresp", `RESP_SLVERR, resp)
        axi_rd(8'h6C);
        `CHK("bad rresp", `RESP_SLVERR, resp)
        `CHK("bad rdata", 32'h0, rd)
        for (int k = 0; k < 2; k++) begin
            polarity_inverted_det <= 1'h1;
            repeat (6) @(posedge core_clk);
            polarity_inverted_det <= 1'h0;
            pol_m = 1'h1;
            repeat (5) @(posedge core_clk);
            chk_out();
            if (k == 0) begin
                axi_rd(`TENMB_SC_ADDR);
                `CHK("pol read", exp_sc(), rd)
            end else begin
                port_status_read <= 1'h1;
                repeat (6) @(posedge core_clk);
                port_status_read <= 1'h0;
            end
            pol_m = 1'h0;
            repeat (5) @(posedge core_clk);
            axi_rd(`TENMB_SC_ADDR);
            `CHK("pol clear", exp_sc(), rd)
            chk_out();
        end
        do_reset(4);
        summarize();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        summarize();
    end
endmodule // tb

/* File: tb/ten_base_t_control_regs_sva.sv */
`timescale 1ns/1ps
`include "ten_base_t_defines.vh"
module ten_base_t_control_regs_sva (
    // Clock and reset
    input wire core_clk,
    input wire rst_n,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    // Device inputs
    input wire ext_tenmb_link_force,
    input wire basic_loopback,
    input wire polarity_inverted_det,
    input wire speed_100,
    input wire full_duplex,
    input wire tp_mode_10,
    // Controls
    input wire tenmb_loopback_active,
    input wire link_pulse_tx_off,
    input wire link_good_force,
    input wire sqe_test_off,
    input wire long_tx_guard_off,
    input wire polarity_status
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("Write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer dropped");
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr != `PORT_CTRL_ADDR && s_axi_araddr != `TENMB_SC_ADDR
        |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("Bad read answer");
    a_bit15_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0)
        else $error("Upper read bits not zero");
    a_sqe_forced: assert property ((speed_100 || full_duplex) [*4] |=> sqe_test_off)
        else $error("Heartbeat not forced off");
    a_jabber_gate: assert property ((!tp_mode_10) [*4] |=> !long_tx_guard_off)
        else $error("Jabber off outside mode");
    a_link_force: assert property (ext_tenmb_link_force [*4]
        |=> link_pulse_tx_off && link_good_force) else $error("Forced link ignored");
    a_loop_block: assert property (basic_loopback [*4] |=> !tenmb_loopback_active)
        else $error("Loopback not blocked");
    a_pol_latch: assert property (polarity_inverted_det [*4] |=> polarity_status)
        else $error("Polarity not latched");
endmodule // ten_base_t_control_regs_sva

bind ten_base_t_control_regs ten_base_t_control_regs_sva i_ten_base_t_control_regs_sva (
    .core_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .ext_tenmb_link_force, .basic_loopback,
    .polarity_inverted_det, .speed_100, .full_duplex, .tp_mode_10, .tenmb_loopback_active,
    .link_pulse_tx_off, .link_good_force, .sqe_test_off, .long_tx_guard_off, .polarity_status
);
